// ==== pcm_port_pkg.sv ====
// constants for the pcm port timing, prescaler and power control block
package pcm_port_pkg;

  // serial word length on the transmit and receive lines
  localparam int unsigned WORD_BITS = 13;
  localparam logic [3:0] BIT_IDX_LAST = 4'hD;
  localparam logic [3:0] BIT_IDX_PENULT = 4'hC;
  localparam logic [3:0] BIT_IDX_FIRST = 4'h1;
  localparam logic [3:0] BIT_IDX_IDLE = 4'h0;

  // master clock edges per 125 us frame for the eight accepted rates
  localparam int unsigned RATE_COUNT = 8;
  localparam logic [9:0] MCLK_FRAME_COUNTS [RATE_COUNT] = '{
    10'h020,  // 256 kHz
    10'h040,  // 512 kHz
    10'h0C0,  // 1536 kHz
    10'h0C1,  // 1544 kHz
    10'h100,  // 2048 kHz
    10'h140,  // 2560 kHz
    10'h200,  // 4096 kHz
    10'h258   // 4800 kHz
  };
  localparam logic [9:0] FRAME_CNT_MAX = 10'h3FF;
  localparam logic [9:0] FRAME_CNT_ONE = 10'h001;

  // 256 kHz codec ticks per 8 kHz frame
  localparam logic [10:0] CODEC_TICKS_PER_FRAME = 11'h020;
  localparam logic [4:0] SAMPLE_PHASE_LAST = 5'h1F;
  localparam logic [4:0] SAMPLE_PHASE_ONE = 5'h01;

  // transmit frame syncs the output stays released after power-up
  localparam logic [1:0] GUARD_FRAMES = 2'h2;
  localparam logic [1:0] GUARD_ONE = 2'h1;

  // consecutive high falling-edge samples that mark a long frame sync
  localparam logic [1:0] LONG_SYNC_SAMPLES = 2'h2;
  localparam logic [1:0] SYNC_SAMPLE_ONE = 2'h1;

  // pin positions in the synchroniser vector
  localparam int unsigned PIN_COUNT = 7;
  localparam int unsigned PIN_MCLK = 6;
  localparam int unsigned PIN_TBC = 5;
  localparam int unsigned PIN_RBC = 4;
  localparam int unsigned PIN_TFS = 3;
  localparam int unsigned PIN_RFS = 2;
  localparam int unsigned PIN_RXD = 1;
  localparam int unsigned PIN_PUI = 0;

endpackage

// ==== pin_sync.sv ====
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // pin_sync

// ==== pcm_port_clock_power_control.sv ====
// pcm serial port timing, master clock prescaler and power-state control
// Operation
// - accept eight master clock rates 256-4800 kHz
// - prescaler makes 256 kHz and 8 kHz ticks
// - division ratio measured against frame sync
// - both syncs low a frame: standby
// - power-up input low forces power-down
// - output released two frame syncs after power-up
// - transmit data changes on rising bit clock
// - receive data sampled on falling bit clock
// - long frame: first bit after later rise
// - long frame: release after later fall
// - short frame: release at falling within lsb
// - two high samples long, one short
`timescale 1ns/100ps
module pcm_port_clock_power_control (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        master_clock,
  input  wire logic        tx_bit_clock,
  input  wire logic        rx_bit_clock,
  input  wire logic        tx_frame_sync,
  input  wire logic        rx_frame_sync,
  input  wire logic        rx_serial_in,
  input  wire logic        power_up_input,
  input  wire logic [12:0] tx_word,
  output logic             tx_serial_out,
  output logic             tx_serial_oe_n,
  output logic [12:0]      rx_word,
  output logic             rx_word_valid,
  output logic             codec_tick,
  output logic             sample_tick,
  output logic             rate_locked,
  output logic             long_frame,
  output logic             standby,
  output logic             powered_down
);

  logic [pcm_port_pkg::PIN_COUNT-1:0] pins_s;
  logic [pcm_port_pkg::PIN_COUNT-1:0] pins_d_r;
  logic mck_rise, tbc_rise, tbc_fall, rbc_fall, tfs_rise, rfs_rise;
  logic tbc_s, tfs_s, rfs_s, rxd_s;

  pin_sync #(
    .WIDTH (pcm_port_pkg::PIN_COUNT)
  ) u_pin_sync (
    .clk (clk),
    .rst (rst),
    .d   ({master_clock, tx_bit_clock, rx_bit_clock, tx_frame_sync,
           rx_frame_sync, rx_serial_in, power_up_input}),
    .q   (pins_s)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      pins_d_r <= '0;
    end else begin
      pins_d_r <= pins_s;
    end
  end

  assign tbc_s    = pins_s[pcm_port_pkg::PIN_TBC];
  assign tfs_s    = pins_s[pcm_port_pkg::PIN_TFS];
  assign rfs_s    = pins_s[pcm_port_pkg::PIN_RFS];
  assign rxd_s    = pins_s[pcm_port_pkg::PIN_RXD];
  assign mck_rise = pins_s[pcm_port_pkg::PIN_MCLK] & ~pins_d_r[pcm_port_pkg::PIN_MCLK];
  assign tbc_rise = tbc_s & ~pins_d_r[pcm_port_pkg::PIN_TBC];
  assign tbc_fall = ~tbc_s & pins_d_r[pcm_port_pkg::PIN_TBC];
  assign rbc_fall = ~pins_s[pcm_port_pkg::PIN_RBC] & pins_d_r[pcm_port_pkg::PIN_RBC];
  assign tfs_rise = tfs_s & ~pins_d_r[pcm_port_pkg::PIN_TFS];
  assign rfs_rise = rfs_s & ~pins_d_r[pcm_port_pkg::PIN_RFS];

  // ---------------- prescaler ----------------
  logic [9:0]  frame_cnt_r;
  logic [9:0]  mcount_r;
  logic [10:0] acc_r;
  logic [10:0] acc_sum;
  logic [4:0]  phase_r;
  logic        rate_match;

  // any of the eight table rates works, including one shared with the bit clock
  always_comb begin
    rate_match = 1'b0;
    for (int i = 0; i < pcm_port_pkg::RATE_COUNT; i++) begin
      if (frame_cnt_r == pcm_port_pkg::MCLK_FRAME_COUNTS[i]) begin
        rate_match = 1'b1;
      end
    end
  end

  // edges counted between transmit sync rises pick the ratio
  always_ff @(posedge clk) begin
    if (rst) begin
      frame_cnt_r <= '0;
      mcount_r    <= pcm_port_pkg::MCLK_FRAME_COUNTS[0];
      rate_locked <= 1'b0;
    end else if (tfs_rise) begin
      frame_cnt_r <= mck_rise ? pcm_port_pkg::FRAME_CNT_ONE : '0;
      if (rate_match) begin
        mcount_r    <= frame_cnt_r;
        rate_locked <= 1'b1;
      end
    end else if (mck_rise && frame_cnt_r != pcm_port_pkg::FRAME_CNT_MAX) begin
      frame_cnt_r <= frame_cnt_r + pcm_port_pkg::FRAME_CNT_ONE;
    end
  end

  // fractional accumulator keeps 1544 kHz exact at 32 ticks per frame
  assign acc_sum = acc_r + pcm_port_pkg::CODEC_TICKS_PER_FRAME;

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r       <= '0;
      phase_r     <= '0;
      codec_tick  <= 1'b0;
      sample_tick <= 1'b0;
    end else begin
      codec_tick  <= 1'b0;
      sample_tick <= 1'b0;
      if (tfs_rise) begin
        acc_r   <= '0;
        phase_r <= '0;
      end else if (mck_rise && rate_locked && !standby && !powered_down) begin
        if (acc_sum >= {1'b0, mcount_r}) begin
          acc_r       <= acc_sum - {1'b0, mcount_r};
          codec_tick  <= 1'b1;
          phase_r     <= phase_r + pcm_port_pkg::SAMPLE_PHASE_ONE;
          sample_tick <= (phase_r == pcm_port_pkg::SAMPLE_PHASE_LAST);
        end else begin
          acc_r <= acc_sum;
        end
      end
    end
  end

  // ---------------- power states ----------------
  logic [9:0] idle_cnt_r;
  logic [1:0] guard_r;
  logic       drive_ok;

  always_ff @(posedge clk) begin
    if (rst) begin
      powered_down <= 1'b1;
    end else begin
      powered_down <= ~pins_s[pcm_port_pkg::PIN_PUI];
    end
  end

  // idle count advances only on master edges, so a stopped clock never idles in
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_cnt_r <= '0;
      standby    <= 1'b0;
    end else if (tfs_s || rfs_s) begin
      idle_cnt_r <= '0;
      standby    <= 1'b0;
    end else begin
      if (mck_rise && idle_cnt_r != pcm_port_pkg::FRAME_CNT_MAX) begin
        idle_cnt_r <= idle_cnt_r + pcm_port_pkg::FRAME_CNT_ONE;
      end
      if (rate_locked && idle_cnt_r >= mcount_r) begin
        standby <= 1'b1;
      end
    end
  end

  // guard window counted in transmit sync rises after wake-up
  always_ff @(posedge clk) begin
    if (rst || powered_down || standby) begin
      guard_r <= '0;
    end else if (tfs_rise && guard_r != pcm_port_pkg::GUARD_FRAMES) begin
      guard_r <= guard_r + pcm_port_pkg::GUARD_ONE;
    end
  end

  assign drive_ok = (guard_r == pcm_port_pkg::GUARD_FRAMES) && !powered_down && !standby;

  // ---------------- sync length classification ----------------
  logic [1:0] tfs_hi_r, rfs_hi_r;
  logic       rx_long_r;

  // mode for a frame comes from the previous sync pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      tfs_hi_r   <= '0;
      long_frame <= 1'b0;
    end else if (tbc_fall) begin
      if (tfs_s) begin
        if (tfs_hi_r != pcm_port_pkg::LONG_SYNC_SAMPLES) begin
          tfs_hi_r <= tfs_hi_r + pcm_port_pkg::SYNC_SAMPLE_ONE;
        end
      end else begin
        tfs_hi_r <= '0;
        if (tfs_hi_r != '0) begin
          long_frame <= (tfs_hi_r == pcm_port_pkg::LONG_SYNC_SAMPLES);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rfs_hi_r  <= '0;
      rx_long_r <= 1'b0;
    end else if (rbc_fall) begin
      if (rfs_s) begin
        if (rfs_hi_r != pcm_port_pkg::LONG_SYNC_SAMPLES) begin
          rfs_hi_r <= rfs_hi_r + pcm_port_pkg::SYNC_SAMPLE_ONE;
        end
      end else begin
        rfs_hi_r <= '0;
        if (rfs_hi_r != '0) begin
          rx_long_r <= (rfs_hi_r == pcm_port_pkg::LONG_SYNC_SAMPLES);
        end
      end
    end
  end

  // ---------------- transmit shifter ----------------
  logic [12:0] tx_sh_r;
  logic [3:0]  tx_idx_r;
  logic        tx_pend_r, tx_lsb_done_r;

  always_ff @(posedge clk) begin
    if (rst || !drive_ok) begin
      tx_sh_r        <= '0;
      tx_idx_r       <= pcm_port_pkg::BIT_IDX_IDLE;
      tx_pend_r      <= 1'b0;
      tx_lsb_done_r  <= 1'b0;
      tx_serial_out  <= 1'b0;
      tx_serial_oe_n <= 1'b1;
    end else if (tfs_rise && long_frame) begin
      tx_lsb_done_r <= 1'b0;
      if (tbc_s) begin
        tx_serial_out  <= tx_word[pcm_port_pkg::WORD_BITS-1];
        tx_serial_oe_n <= 1'b0;
        tx_sh_r        <= tx_word << 1;
        tx_idx_r       <= pcm_port_pkg::BIT_IDX_FIRST;
        tx_pend_r      <= 1'b0;
      end else begin
        tx_sh_r   <= tx_word;
        tx_pend_r <= 1'b1;
      end
    end else if (tbc_fall && tfs_s && tfs_hi_r == '0 && !long_frame) begin
      tx_sh_r       <= tx_word;
      tx_pend_r     <= 1'b1;
      tx_lsb_done_r <= 1'b0;
    end else if (tbc_rise && (tx_pend_r || (tx_idx_r != pcm_port_pkg::BIT_IDX_IDLE &&
                                            tx_idx_r != pcm_port_pkg::BIT_IDX_LAST))) begin
      tx_serial_out  <= tx_sh_r[pcm_port_pkg::WORD_BITS-1];
      tx_serial_oe_n <= 1'b0;
      tx_sh_r        <= tx_sh_r << 1;
      tx_idx_r       <= tx_pend_r ? pcm_port_pkg::BIT_IDX_FIRST : tx_idx_r + 4'h1;
      tx_pend_r      <= 1'b0;
    end else if (tbc_fall && tx_idx_r == pcm_port_pkg::BIT_IDX_LAST) begin
      if (!long_frame || !tfs_s) begin
        tx_serial_oe_n <= 1'b1;
        tx_idx_r       <= pcm_port_pkg::BIT_IDX_IDLE;
      end else begin
        tx_lsb_done_r <= 1'b1;
      end
    end else if (tx_lsb_done_r && !tfs_s) begin
      tx_serial_oe_n <= 1'b1;
      tx_idx_r       <= pcm_port_pkg::BIT_IDX_IDLE;
      tx_lsb_done_r  <= 1'b0;
    end
  end

  // ---------------- receive shifter ----------------
  logic [12:0] rx_sh_r;
  logic [3:0]  rx_idx_r;
  logic        rx_arm_r, rx_take;

  assign rx_take = rbc_fall && !powered_down && !standby &&
                   ((rfs_s && rfs_hi_r == '0 && rx_long_r) || rx_arm_r ||
                    rx_idx_r != pcm_port_pkg::BIT_IDX_IDLE);

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_sh_r       <= '0;
      rx_idx_r      <= pcm_port_pkg::BIT_IDX_IDLE;
      rx_arm_r      <= 1'b0;
      rx_word       <= '0;
      rx_word_valid <= 1'b0;
    end else begin
      rx_word_valid <= 1'b0;
      if (rx_take) begin
        rx_sh_r  <= {rx_sh_r[11:0], rxd_s};
        rx_arm_r <= 1'b0;
        if (rx_idx_r == pcm_port_pkg::BIT_IDX_PENULT) begin
          rx_word       <= {rx_sh_r[11:0], rxd_s};
          rx_word_valid <= 1'b1;
          rx_idx_r      <= pcm_port_pkg::BIT_IDX_IDLE;
        end else begin
          rx_idx_r <= rx_idx_r + 4'h1;
        end
      end else if (rbc_fall && rfs_s && rfs_hi_r == '0 && !rx_long_r) begin
        rx_arm_r <= 1'b1;
      end
    end
  end

  // ---------------- checks ----------------
  a_powerdown_hiz: assert property (@(posedge clk) disable iff (rst)
    powered_down |=> tx_serial_oe_n)
    else $error("output driven during power-down");

  a_standby_hiz: assert property (@(posedge clk) disable iff (rst)
    standby |=> tx_serial_oe_n)
    else $error("output driven during standby");

  a_guard_hiz: assert property (@(posedge clk) disable iff (rst)
    (guard_r != pcm_port_pkg::GUARD_FRAMES) |=> tx_serial_oe_n)
    else $error("output driven inside guard frames");

  a_tx_change_edge: assert property (@(posedge clk) disable iff (rst)
    (!tx_serial_oe_n && $changed(tx_serial_out)) |-> $past(tbc_rise) || $past(tfs_rise))
    else $error("transmit data changed off a rising edge");

  a_release_edge: assert property (@(posedge clk) disable iff (rst)
    $rose(tx_serial_oe_n) |-> $past(tbc_fall) || $past(!tfs_s) || $past(!drive_ok))
    else $error("output released without a falling edge");

  a_rx_on_fall: assert property (@(posedge clk) disable iff (rst)
    $changed(rx_idx_r) |-> $past(rbc_fall))
    else $error("receive bit taken off a falling edge");

  a_long_classify: assert property (@(posedge clk) disable iff (rst)
    (tbc_fall && !tfs_s && tfs_hi_r == pcm_port_pkg::LONG_SYNC_SAMPLES) |=> long_frame)
    else $error("long sync not classified as long");

  a_standby_entry: assert property (@(posedge clk) disable iff (rst)
    (rate_locked && !tfs_s && !rfs_s && idle_cnt_r >= mcount_r) ##1 (!tfs_s && !rfs_s) |-> standby)
    else $error("standby not entered after idle frame");

  a_sample_on_tick: assert property (@(posedge clk) disable iff (rst)
    sample_tick |-> codec_tick && $past(phase_r) == pcm_port_pkg::SAMPLE_PHASE_LAST)
    else $error("sample tick not on 32nd codec tick");

  a_rate_table: assert property (@(posedge clk) disable iff (rst)
    (tfs_rise && rate_match) |=> mcount_r == $past(frame_cnt_r) && rate_locked)
    else $error("measured rate not adopted");

endmodule // pcm_port_clock_power_control

// ==== pcm_highway_model.sv ====
// behavioural pcm highway controller: clocks, frame syncs and serial words
`timescale 1ns/100ps
module pcm_highway_model (
  input  wire logic        clk,
  input  wire logic        sync_en,
  input  wire logic        long_mode,
  input  wire logic [9:0]  mclk_count,
  input  wire logic [5:0]  mclk_period,
  input  wire logic [12:0] rx_data,
  input  wire logic        tx_serial_out,
  input  wire logic        tx_serial_oe_n,
  output logic             master_clock,
  output logic             bit_clock,
  output logic             frame_sync,
  output logic             rx_serial_in,
  output logic             frame_start,
  output logic [12:0]      tx_last,
  output logic [4:0]       nbits_last,
  output logic             stray_last
);
  // time-scaled frame so a run stays short: mclk_count master periods per sync
  localparam int BIT_CYC = 52;
  int          cyc = 0;
  int          k;
  int          lim;
  logic [12:0] tx_cap = 13'h0000;
  logic [4:0]  nbits = 5'h00;
  logic        stray = 1'b0;

  initial begin
    master_clock = 1'b0;
    bit_clock = 1'b0;
    frame_sync = 1'b0;
    rx_serial_in = 1'b0;
    frame_start = 1'b0;
    tx_last = 13'h0000;
    nbits_last = 5'h00;
    stray_last = 1'b0;
  end

  always @(posedge clk) begin
    k = cyc / BIT_CYC - (long_mode ? 0 : 1);
    lim = BIT_CYC * (long_mode ? 12 : 13) + BIT_CYC / 2 + 8;
    frame_start <= (cyc == 0);
    // with a 52-cycle period the master clock is the bit clock itself
    master_clock <= (cyc % mclk_period) < (mclk_period / 2);
    bit_clock <= (cyc % BIT_CYC) < (BIT_CYC / 2);
    // one rise per frame, low far longer than a bit period between pulses
    frame_sync <= sync_en && cyc >= 10 && cyc < (long_mode ? 166 : 40);
    // outside the word the line toggles so stale data never looks valid
    if (cyc % BIT_CYC == 0)
      rx_serial_in <= (sync_en && k >= 0 && k < 13) ? rx_data[12 - k] : !rx_serial_in;
    if (cyc % BIT_CYC == BIT_CYC / 2 && k >= 0 && k < 13 && !tx_serial_oe_n) begin
      tx_cap[12 - k] <= tx_serial_out;
      nbits <= nbits + 5'h01;
    end
    if (!tx_serial_oe_n && (cyc < 10 || cyc > lim))
      stray <= 1'b1;
    if (cyc + 1 >= mclk_count * mclk_period) begin
      cyc <= 0;
      tx_last <= tx_cap;
      nbits_last <= nbits;
      stray_last <= stray;
      nbits <= 5'h00;
      stray <= 1'b0;
    end else begin
      cyc <= cyc + 1;
    end
  end
endmodule // pcm_highway_model

// ==== test_pcm_port_clock_power_control.sv ====
// self-checking testbench of the pcm port timing and power control block
`timescale 1ns/100ps
module test_pcm_port_clock_power_control;
  logic        clk, rst, power_up_input, sync_en, long_mode;
  logic [9:0]  mclk_count;
  logic [5:0]  mclk_period;
  logic [12:0] tx_word, rx_data;
  logic        master_clock, bit_clock, frame_sync, rx_serial_in, frame_start;
  logic        tx_serial_out, tx_serial_oe_n, rx_word_valid, codec_tick, sample_tick;
  logic        rate_locked, long_frame, standby, powered_down, stray_last;
  logic [12:0] rx_word, tx_last;
  logic [4:0]  nbits_last;
  int          mismatches = 0;
  int          n_checks = 0;
  int          flen = 1664;
  int          rx_valid_seen = 0;

  // received-word strobes, judged once the traffic tests are over
  always @(posedge clk) begin
    if (rx_word_valid === 1'b1)
      rx_valid_seen <= rx_valid_seen + 1;
  end

  pcm_highway_model i_pcm_highway_model (.clk(clk), .sync_en(sync_en), .long_mode(long_mode),
    .mclk_count(mclk_count), .mclk_period(mclk_period), .rx_data(rx_data), .tx_serial_out(tx_serial_out),
    .tx_serial_oe_n(tx_serial_oe_n), .master_clock(master_clock), .bit_clock(bit_clock),
    .frame_sync(frame_sync), .rx_serial_in(rx_serial_in), .frame_start(frame_start), .tx_last(tx_last),
    .nbits_last(nbits_last), .stray_last(stray_last));

  pcm_port_clock_power_control i_pcm_port_clock_power_control (.clk(clk), .rst(rst),
    .master_clock(master_clock), .tx_bit_clock(bit_clock), .rx_bit_clock(bit_clock),
    .tx_frame_sync(frame_sync), .rx_frame_sync(frame_sync), .rx_serial_in(rx_serial_in),
    .power_up_input(power_up_input), .tx_word(tx_word), .tx_serial_out(tx_serial_out),
    .tx_serial_oe_n(tx_serial_oe_n), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
    .codec_tick(codec_tick), .sample_tick(sample_tick), .rate_locked(rate_locked),
    .long_frame(long_frame), .standby(standby), .powered_down(powered_down));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // returns just after the model snapshots a finished frame
  task automatic frames(input int n);
    int i;
    repeat (n) begin
      i = 0;
      do begin
        @(posedge clk);
        i++;
      end while (frame_start !== 1'b1 && i < 4000);
    end
  endtask

  task automatic count_ticks(output int ct, output int st);
    ct = 0;
    st = 0;
    repeat (flen) begin
      @(posedge clk);
      ct += (codec_tick === 1'b1);
      st += (sample_tick === 1'b1);
    end
  endtask

  // a whole word on the line, nothing outside its slot, received word matched
  task automatic check_word(input logic [12:0] exp_tx, input logic [12:0] exp_rx);
    check("tx_bits", nbits_last, 13);
    check("tx_word_on_line", tx_last, exp_tx);
    check("tx_release", stray_last, 0);
    check("rx_word", rx_word, exp_rx);
  endtask

  task automatic t_rates;
    int ct, st, cnt;
    for (int r = 0; r < 8; r++) begin
      cnt = int'(pcm_port_pkg::MCLK_FRAME_COUNTS[r]);
      @(posedge clk);
      mclk_count <= pcm_port_pkg::MCLK_FRAME_COUNTS[r];
      mclk_period <= 6'((1664 + cnt - 1) / cnt);
      flen = cnt * ((1664 + cnt - 1) / cnt);
      // one mixed frame, one measured frame, then a frame on the new ratio only
      frames(3);
      check("rate_locked", rate_locked, 1);
      count_ticks(ct, st);
      check("codec_ticks", ct, 32);
      check("sample_ticks", st, 1);
    end
    $display("test rates done");
  endtask

  task automatic t_power;
    int i;
    frames(1);
    i = 0;
    while (tx_serial_oe_n !== 1'b0 && i < 2000) begin
      @(posedge clk);
      i++;
    end
    power_up_input <= 1'b0;
    // 2 sync + 1 state + 1 release, then one more edge so the release has settled
    repeat (5) @(posedge clk);
    check("powered_down", powered_down, 1);
    check("oe_n_abort", tx_serial_oe_n, 1);
    frames(2);
    check("bits_powered_down", nbits_last, 0);
    tx_word <= 13'h1A5C;
    power_up_input <= 1'b1;
    frames(1);
    check("guard_frame", nbits_last, 0);
    check("awake", powered_down, 0);
    frames(3);
    check_word(13'h1A5C, 13'h0B3E);
    check("short_mode", long_frame, 0);
    $display("test power done");
  endtask

  task automatic t_long;
    long_mode <= 1'b1;
    tx_word <= 13'h0F31;
    rx_data <= 13'h1C47;
    frames(3);
    check("long_mode", long_frame, 1);
    check_word(13'h0F31, 13'h1C47);
    long_mode <= 1'b0;
    tx_word <= 13'h10C2;
    frames(3);
    check("back_short", long_frame, 0);
    check_word(13'h10C2, 13'h1C47);
    $display("test long done");
  endtask

  task automatic t_standby;
    int ct, st;
    sync_en <= 1'b0;
    frames(3);
    check("standby", standby, 1);
    check("bits_standby", nbits_last, 0);
    count_ticks(ct, st);
    check("ticks_standby", ct, 0);
    sync_en <= 1'b1;
    frames(1);
    check("standby_exit", standby, 0);
    check("guard_after_standby", nbits_last, 0);
    frames(3);
    check_word(13'h10C2, 13'h1C47);
    check("rx_valid_seen", rx_valid_seen != 0, 1);
    $display("test standby done");
  endtask

  initial begin
    rst = 1'b1;
    power_up_input = 1'b1;
    sync_en = 1'b1;
    long_mode = 1'b0;
    mclk_count = 10'h020;
    mclk_period = 6'h34;
    tx_word = 13'h1A5C;
    rx_data = 13'h0B3E;
    repeat (20) @(posedge clk);
    check("reset_oe_n", tx_serial_oe_n, 1);
    check("reset_powered_down", powered_down, 1);
    check("reset_locked", rate_locked, 0);
    rst <= 1'b0;
    t_rates;
    t_power;
    t_long;
    t_standby;
    report_and_stop;
  end

  // about 95k cycles are expected; the bound keeps the run under 100k
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    $display("ERROR watchdog expected done seen hang");
    report_and_stop;
  end
endmodule // test_pcm_port_clock_power_control
